// File: vafrc_top.sv
// Alarm, FIR bank and decimation rate configuration registers behind the serial port
//
// What this block does
// RQ1 - Alarm config bit 12 keeps spectral flags set across status reads.
// RQ2 - Spectral flag rises only after delay-field count of exceeding records.
// RQ3 - Bit 7 latches error flags until the clear-status command.
// RQ4 - Bit 6 routes alarm 1 and alarm 2 to the two alarm pins.
// RQ5 - Bit 5 sets system alarm polarity: one below, zero above threshold.
// RQ6 - Bit 4 picks temperature (one) or supply (zero) for the system alarm.
// RQ7 - Bits 3..0 enable system, z, y, x alarms; disabled ones never flag.
// RQ8 - Filter select resets to zero, bypassing every filter on all axes.
// RQ9 - Three-bit bank select per axis: z 10..8, y 6..4, x 2..0.
// RQ10 - Code 0 none, 1..3 low-pass 1/5/10 kHz, 4..6 high-pass 1/5/10 kHz.
// RQ11 - Each bank is a 32-tap FIR on the selected axis stream.
// RQ12 - Rate settings enabled by record config apply only in three capture modes.
// RQ13 - Each rate nibble is a scale 1..7; rate is 220000 over two to it.
// RQ14 - Rate settings 0..3 sit in nibbles 3..0, 7..4, 11..8, 15..12.
// RQ15 - Rate register resets to 0x7421.
// RQ16 - Host writes one byte per 16-bit word: bit 15 set, address, data.
// RQ17 - A write to the odd address changes only the upper byte.
// RQ18 - Reserved bits ignore writes and read as zero.
// RQ19 - Diagnostic flags: system 14, alarm 2 z/y/x 13..11, alarm 1 10..8.
// RQ20 - Global command bit 4 clears the diagnostic flags once, self-clearing.
`timescale 1ns/1ps
`default_nettype none
module vafrc_top #(
  parameter int DELAY_W = vafrc_pkg::CFG_DELAY_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  output logic spi_dout,
  input wire logic record_done,
  input wire vafrc_pkg::vafrc_spectral_t spectral_exceed,
  input wire logic system_sample,
  input wire logic [15:0] temperature_value,
  input wire logic [15:0] supply_value,
  input wire logic [15:0] system_alarm_threshold,
  input wire logic [vafrc_pkg::DIAG_ERR_W-1:0] error_events,
  input wire logic data_ready,
  input wire logic [1:0] capture_mode,
  input wire logic [3:0] record_rate_enable,
  output logic alarm_output_pin_1,
  output logic alarm_output_pin_2,
  output vafrc_pkg::vafrc_fir_sel_t fir_select,
  output logic [2:0] fir_bypass,
  output logic [15:0] decimation_rates_out,
  output logic [3:0] rate_enable_active
);

  typedef struct packed {
    logic [15:0] alarm_cfg;
    logic [15:0] fir_sel;
    logic [15:0] rates;
    logic [15:0] diag;
    logic [15:0] tx;
    logic pin1;
    logic pin2;
    logic [2:0] bypass;
    logic [3:0] rate_act;
  } vafrc_top_st_t;

  vafrc_top_st_t st;
  vafrc_top_st_t next_st;

  if (DELAY_W != vafrc_pkg::CFG_DELAY_W) begin : g_chk
    $error("vafrc_top: DELAY_W must match the response delay field");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte write into a word; reserved bits are forced to zero
  function automatic logic [15:0] vafrc_byte_wr(input logic [15:0] old,
                                                input logic upper,
                                                input logic [7:0] data,
                                                input logic [15:0] mask);
    logic [15:0] val;
    val = upper ? {data, old[7:0]} : {old[15:8], data}; // RQ17
    return val & mask; // RQ18
  endfunction

  // A filter code of zero or an unused code means no filtering
  function automatic logic vafrc_is_bypass(input logic [2:0] code);
    return (code == vafrc_pkg::FIR_NONE) || (code == 3'h7); // RQ10
  endfunction

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  logic frame_done;
  logic frame_bad;
  logic [15:0] rx_word;

  vafrc_spi u_spi (
    .sys_clk(sys_clk),
    .srst(srst),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .din(spi_din),
    .tx_word(st.tx),
    .dout(spi_dout),
    .frame_done(frame_done),
    .frame_bad(frame_bad),
    .rx_word(rx_word)
  );

  // ----------------------------------------------------------------
  // Spectral alarm response delay
  // ----------------------------------------------------------------
  vafrc_pkg::vafrc_spectral_t spectral_hit;
  logic [DELAY_W-1:0] resp_delay;
  logic [2:0] axis_en;

  assign resp_delay = st.alarm_cfg[vafrc_pkg::CFG_DELAY_LSB +: DELAY_W];
  assign axis_en = st.alarm_cfg[vafrc_pkg::CFG_AXIS_EN_LSB +: 3];

  for (genvar i = 0; i < 6; i++) begin : g_delay
    vafrc_delay #(
      .DELAY_W(DELAY_W)
    ) u_delay (
      .sys_clk(sys_clk),
      .srst(srst),
      .record_done(record_done),
      .exceed(spectral_exceed[i]),
      .enable(axis_en[i % 3]),
      .delay(resp_delay),
      .hit(spectral_hit[i])
    );
  end

  // ----------------------------------------------------------------
  // Register file and flags
  // ----------------------------------------------------------------
  logic wr_cmd;
  logic rd_cmd;
  logic [6:0] cmd_addr;
  logic [6:0] word_addr;
  logic [7:0] cmd_data;
  logic [15:0] sys_value;
  logic sys_trig;
  logic diag_clear;
  logic spec_clear;
  logic [15:0] diag_set;
  logic [15:0] rd_val;
  logic [vafrc_pkg::DIAG_ERR_W-1:0] err_now;

  assign wr_cmd = frame_done && rx_word[vafrc_pkg::WR_BIT]; // RQ16
  assign rd_cmd = frame_done && !rx_word[vafrc_pkg::WR_BIT];
  assign cmd_addr = rx_word[vafrc_pkg::ADDR_MSB:vafrc_pkg::ADDR_LSB];
  assign word_addr = {cmd_addr[6:1], 1'b0};
  assign cmd_data = rx_word[vafrc_pkg::DATA_MSB:0];

  always_comb begin
    next_st = st;

    // Byte writes; the upper byte is reached at the odd address
    if (wr_cmd) begin
      unique case (word_addr)
        vafrc_pkg::ADDR_ALARM_CFG: next_st.alarm_cfg = vafrc_byte_wr(st.alarm_cfg,
            cmd_addr[0], cmd_data, vafrc_pkg::MASK_ALARM_CFG); // RQ16
        vafrc_pkg::ADDR_FIR_SEL: next_st.fir_sel = vafrc_byte_wr(st.fir_sel,
            cmd_addr[0], cmd_data, vafrc_pkg::MASK_FIR_SEL); // RQ9
        vafrc_pkg::ADDR_RATES: next_st.rates = vafrc_byte_wr(st.rates,
            cmd_addr[0], cmd_data, vafrc_pkg::MASK_RATES); // RQ14
        default: next_st.rates = st.rates;
      endcase
    end

    // Clear-status command acts once; the command bit itself is never stored
    diag_clear = wr_cmd && (word_addr == vafrc_pkg::ADDR_GCMD) && !cmd_addr[0]
                 && cmd_data[vafrc_pkg::GCMD_CLR_BIT]; // RQ20
    spec_clear = rd_cmd && (word_addr == vafrc_pkg::ADDR_DIAG)
                 && !st.alarm_cfg[vafrc_pkg::CFG_KEEP_BIT]; // RQ1

    // System alarm compare
    sys_value = st.alarm_cfg[vafrc_pkg::CFG_SRC_BIT] ? temperature_value
                                                       : supply_value; // RQ6
    sys_trig = st.alarm_cfg[vafrc_pkg::CFG_POL_BIT]
               ? (sys_value < system_alarm_threshold)
               : (sys_value > system_alarm_threshold); // RQ5

    diag_set = vafrc_pkg::ZERO_WORD;
    diag_set[vafrc_pkg::DIAG_SYS_BIT] = system_sample && sys_trig
        && st.alarm_cfg[vafrc_pkg::CFG_SYS_EN_BIT]; // RQ7
    diag_set[vafrc_pkg::DIAG_A1_LSB +: 3] = spectral_hit.alarm1; // RQ19
    diag_set[vafrc_pkg::DIAG_A2_LSB +: 3] = spectral_hit.alarm2; // RQ19

    // Alarm flags: a set in the same cycle as a clear wins
    next_st.diag[vafrc_pkg::DIAG_SYS_BIT] = (st.diag[vafrc_pkg::DIAG_SYS_BIT]
        && !diag_clear) || diag_set[vafrc_pkg::DIAG_SYS_BIT];
    next_st.diag[vafrc_pkg::DIAG_A1_LSB +: 6] =
        (st.diag[vafrc_pkg::DIAG_A1_LSB +: 6] & {6{!(diag_clear || spec_clear)}})
        | diag_set[vafrc_pkg::DIAG_A1_LSB +: 6]; // RQ1

    // Error flags: sticky when latching, otherwise they follow the events
    err_now = error_events;
    err_now[vafrc_pkg::DIAG_SPI_BIT] = error_events[vafrc_pkg::DIAG_SPI_BIT] || frame_bad;
    if (st.alarm_cfg[vafrc_pkg::CFG_LATCH_BIT]) begin
      next_st.diag[vafrc_pkg::DIAG_ERR_W-1:0] =
          (st.diag[vafrc_pkg::DIAG_ERR_W-1:0] & {vafrc_pkg::DIAG_ERR_W{!diag_clear}})
          | err_now; // RQ3
    end else begin
      next_st.diag[vafrc_pkg::DIAG_ERR_W-1:0] = err_now; // RQ3
    end
    next_st.diag[vafrc_pkg::DIAG_READY_BIT] = data_ready;
    next_st.diag[15] = 1'b0; // RQ18

    // Read answer is shifted out during the next frame
    unique case (word_addr)
      vafrc_pkg::ADDR_ALARM_CFG: rd_val = st.alarm_cfg;
      vafrc_pkg::ADDR_FIR_SEL: rd_val = st.fir_sel;
      vafrc_pkg::ADDR_RATES: rd_val = st.rates;
      vafrc_pkg::ADDR_DIAG: rd_val = st.diag;
      default: rd_val = vafrc_pkg::ZERO_WORD; // RQ18
    endcase
    if (rd_cmd) begin
      next_st.tx = rd_val;
    end else if (frame_done) begin
      next_st.tx = vafrc_pkg::ZERO_WORD;
    end

    // Alarm pins follow the flags only when routed
    next_st.pin1 = next_st.alarm_cfg[vafrc_pkg::CFG_PIN_EN_BIT]
                   && |next_st.diag[vafrc_pkg::DIAG_A1_LSB +: 3]; // RQ4
    next_st.pin2 = next_st.alarm_cfg[vafrc_pkg::CFG_PIN_EN_BIT]
                   && |next_st.diag[vafrc_pkg::DIAG_A2_LSB +: 3]; // RQ4

    // Filter datapath steering; the 32-tap banks themselves sit downstream
    next_st.bypass = {vafrc_is_bypass(next_st.fir_sel[vafrc_pkg::FIR_Z_LSB +: 3]),
                      vafrc_is_bypass(next_st.fir_sel[vafrc_pkg::FIR_Y_LSB +: 3]),
                      vafrc_is_bypass(next_st.fir_sel[vafrc_pkg::FIR_X_LSB +: 3])}; // RQ8 RQ11

    // Decimated rates serve only the two spectrum modes and manual time capture
    next_st.rate_act = ((capture_mode == vafrc_pkg::MODE_MAN_SPECTRUM)
                        || (capture_mode == vafrc_pkg::MODE_AUTO_SPECTRUM)
                        || (capture_mode == vafrc_pkg::MODE_MAN_TIME))
                       ? record_rate_enable : 4'h0; // RQ12
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '{alarm_cfg: vafrc_pkg::RST_ALARM_CFG,
              fir_sel: vafrc_pkg::RST_FIR_SEL, // RQ8
              rates: vafrc_pkg::RST_RATES, // RQ15
              diag: vafrc_pkg::RST_DIAG,
              tx: vafrc_pkg::ZERO_WORD,
              pin1: 1'b0,
              pin2: 1'b0,
              bypass: 3'h7,
              rate_act: 4'h0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all taken from the state register
  // ----------------------------------------------------------------
  assign alarm_output_pin_1 = st.pin1;
  assign alarm_output_pin_2 = st.pin2;
  assign fir_select = '{z: st.fir_sel[vafrc_pkg::FIR_Z_LSB +: 3],
                        y: st.fir_sel[vafrc_pkg::FIR_Y_LSB +: 3],
                        x: st.fir_sel[vafrc_pkg::FIR_X_LSB +: 3]}; // RQ9
  assign fir_bypass = st.bypass;
  // Scale factors 1..7 give 220000 / 2**n samples per second downstream
  assign decimation_rates_out = st.rates; // RQ13
  assign rate_enable_active = st.rate_act;

endmodule
`default_nettype wire

// File: vafrc_pkg.sv
// Shared constants and types of the vibration alarm, filter and rate configuration block
package vafrc_pkg;

  // ----------------------------------------------------------------
  // Serial command word
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam int WR_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;

  // ----------------------------------------------------------------
  // Byte addresses, even byte of each word
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_ALARM_CFG = 7'h34;
  localparam logic [6:0] ADDR_FIR_SEL = 7'h38;
  localparam logic [6:0] ADDR_RATES = 7'h3A;
  localparam logic [6:0] ADDR_DIAG = 7'h3C;
  localparam logic [6:0] ADDR_GCMD = 7'h3E;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ALARM_CFG = 16'h0080;
  localparam logic [15:0] RST_FIR_SEL = 16'h0000;
  localparam logic [15:0] RST_RATES = 16'h7421;
  localparam logic [15:0] RST_DIAG = 16'h0000;
  localparam logic [15:0] MASK_ALARM_CFG = 16'h1FFF;
  localparam logic [15:0] MASK_FIR_SEL = 16'h0777;
  localparam logic [15:0] MASK_RATES = 16'hFFFF;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Alarm configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_KEEP_BIT = 12;
  localparam int CFG_DELAY_LSB = 8;
  localparam int CFG_DELAY_W = 4;
  localparam int CFG_LATCH_BIT = 7;
  localparam int CFG_PIN_EN_BIT = 6;
  localparam int CFG_POL_BIT = 5;
  localparam int CFG_SRC_BIT = 4;
  localparam int CFG_SYS_EN_BIT = 3;
  localparam int CFG_AXIS_EN_LSB = 0;

  // ----------------------------------------------------------------
  // Filter select, rates, diagnostic flags, global command
  // ----------------------------------------------------------------
  localparam int FIR_Z_LSB = 8;
  localparam int FIR_Y_LSB = 4;
  localparam int FIR_X_LSB = 0;
  localparam logic [2:0] FIR_NONE = 3'h0;
  localparam int FIR_TAPS = 32;
  localparam int BASE_RATE_SPS = 220000;
  localparam int DIAG_SYS_BIT = 14;
  localparam int DIAG_A2_LSB = 11;
  localparam int DIAG_A1_LSB = 8;
  localparam int DIAG_READY_BIT = 7;
  localparam int DIAG_SPI_BIT = 3;
  localparam int DIAG_ERR_W = 7;
  localparam int GCMD_CLR_BIT = 4;

  // ----------------------------------------------------------------
  // Capture mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_MAN_SPECTRUM = 2'h0;
  localparam logic [1:0] MODE_AUTO_SPECTRUM = 2'h1;
  localparam logic [1:0] MODE_MAN_TIME = 2'h2;
  localparam logic [1:0] MODE_REAL_TIME = 2'h3;

  typedef enum logic [1:0] {
    VAFRC_SPI_IDLE = 2'b01,
    VAFRC_SPI_BUSY = 2'b10
  } vafrc_spi_state_t;

  typedef struct packed {
    logic [2:0] z;
    logic [2:0] y;
    logic [2:0] x;
  } vafrc_fir_sel_t;

  typedef struct packed {
    logic [2:0] alarm2;
    logic [2:0] alarm1;
  } vafrc_spectral_t;

endpackage

// File: vafrc_spi.sv
// Serial command port: 16-bit frames in, read answers out
`timescale 1ns/1ps
`default_nettype none
module vafrc_spi (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [15:0] tx_word,
  output logic dout,
  output logic frame_done,
  output logic frame_bad,
  output logic [15:0] rx_word
);

  typedef struct packed {
    vafrc_pkg::vafrc_spi_state_t state;
    logic sclk_q;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [vafrc_pkg::CNT_W-1:0] cnt;
    logic dout;
    logic done;
    logic bad;
  } vafrc_spi_st_t;

  vafrc_spi_st_t st;
  vafrc_spi_st_t next_st;

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  // Clock idles high; data move out on falling and in on rising edges
  always_comb begin
    next_st = st;
    next_st.sclk_q = sclk;
    next_st.done = 1'b0;
    next_st.bad = 1'b0;
    unique case (st.state)
      vafrc_pkg::VAFRC_SPI_IDLE: begin
        if (!cs_n) begin
          next_st.state = vafrc_pkg::VAFRC_SPI_BUSY;
          next_st.cnt = '0;
          next_st.tx = tx_word;
        end
      end
      vafrc_pkg::VAFRC_SPI_BUSY: begin
        if (cs_n) begin
          next_st.state = vafrc_pkg::VAFRC_SPI_IDLE;
          next_st.dout = 1'b0;
          // A frame that is not exactly one word is dropped and flagged
          if (st.cnt == vafrc_pkg::CNT_W'(vafrc_pkg::FRAME_BITS)) begin
            next_st.done = 1'b1;
          end else begin
            next_st.bad = 1'b1;
          end
        end else begin
          if (sclk && !st.sclk_q) begin
            next_st.rx = {st.rx[14:0], din};
            if (st.cnt <= vafrc_pkg::CNT_W'(vafrc_pkg::FRAME_BITS)) begin
              next_st.cnt = st.cnt + 1'b1;
            end
          end
          if (!sclk && st.sclk_q) begin
            next_st.dout = st.tx[15];
            next_st.tx = {st.tx[14:0], 1'b0};
          end
        end
      end
      default: next_st.state = vafrc_pkg::VAFRC_SPI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '{state: vafrc_pkg::VAFRC_SPI_IDLE, sclk_q: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.dout;
  assign frame_done = st.done;
  assign frame_bad = st.bad;
  assign rx_word = st.rx;

endmodule
`default_nettype wire

// File: vafrc_delay.sv
// Response delay counter for one spectral alarm of one axis
`timescale 1ns/1ps
`default_nettype none
module vafrc_delay #(
  parameter int DELAY_W = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic record_done,
  input wire logic exceed,
  input wire logic enable,
  input wire logic [DELAY_W-1:0] delay,
  output logic hit
);

  typedef struct packed {
    logic [DELAY_W-1:0] cnt;
    logic hit;
  } vafrc_delay_st_t;

  vafrc_delay_st_t st;
  vafrc_delay_st_t next_st;
  logic [DELAY_W-1:0] bumped;

  if (DELAY_W < 1) begin : g_chk
    $error("vafrc_delay: DELAY_W must be at least 1");
  end

  // ----------------------------------------------------------------
  // Consecutive record count
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.hit = 1'b0;
    bumped = (&st.cnt) ? st.cnt : st.cnt + 1'b1;
    if (record_done) begin
      // Disabled alarms never count, so they never raise a flag
      if (!enable || !exceed) begin
        next_st.cnt = '0; // RQ7
      end else begin
        next_st.cnt = bumped;
        next_st.hit = (bumped >= delay); // RQ2
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hit = st.hit;

endmodule
`default_nettype wire

// File: vafrc_top_asserts.sv
// Port assertions of the alarm, filter and rate configuration block
`timescale 1ns/1ps
`default_nettype none
module vafrc_top_asserts (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_dout,
  input wire logic record_done,
  input wire vafrc_pkg::vafrc_spectral_t spectral_exceed,
  input wire logic [1:0] capture_mode,
  input wire logic [3:0] record_rate_enable,
  input wire logic alarm_output_pin_1,
  input wire logic alarm_output_pin_2,
  input wire vafrc_pkg::vafrc_fir_sel_t fir_select,
  input wire logic [2:0] fir_bypass,
  input wire logic [15:0] decimation_rates_out,
  input wire logic [3:0] rate_enable_active
);
  logic [7:0] cs_hist;
  logic cs_recent;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Frame history, since register effects lag a frame by a few edges
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    cs_hist <= srst ? 8'hFF : {cs_hist[6:0], spi_cs_n};
  end
  assign cs_recent = (cs_hist != 8'hFF);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rate_en;
    !$past(srst) |-> rate_enable_active ==
      (($past(capture_mode) == 2'h3) ? 4'h0 : $past(record_rate_enable));
  endproperty
  a_rate_en: assert property (p_rate_en) else $error("rate enable wrong");
  property p_bypass;
    fir_bypass == {fir_select.z inside {3'h0, 3'h7}, fir_select.y inside {3'h0, 3'h7},
      fir_select.x inside {3'h0, 3'h7}};
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  property p_pin1_rise;
    $rose(alarm_output_pin_1) && !$past(srst) |-> cs_recent ||
      ($past(record_done, 2) && $past(spectral_exceed.alarm1, 2) != 3'h0);
  endproperty
  a_pin1_rise: assert property (p_pin1_rise) else $error("pin 1 rose alone");
  property p_pin2_rise;
    $rose(alarm_output_pin_2) && !$past(srst) |-> cs_recent ||
      ($past(record_done, 2) && $past(spectral_exceed.alarm2, 2) != 3'h0);
  endproperty
  a_pin2_rise: assert property (p_pin2_rise) else $error("pin 2 rose alone");
  property p_rates_hold;
    $changed(decimation_rates_out) && !$past(srst) |-> cs_recent;
  endproperty
  a_rates_hold: assert property (p_rates_hold) else $error("rates moved");
  property p_fir_hold;
    $changed(fir_select) && !$past(srst) |-> cs_recent;
  endproperty
  a_fir_hold: assert property (p_fir_hold) else $error("filter select moved");
  property p_dout_idle;
    spi_cs_n && cs_hist[2:0] == 3'h7 |-> !spi_dout;
  endproperty
  a_dout_idle: assert property (p_dout_idle) else $error("dout busy when idle");
  property p_dout_fall;
    $changed(spi_dout) && !$past(srst) |-> !spi_sclk || spi_cs_n;
  endproperty
  a_dout_fall: assert property (p_dout_fall) else $error("dout moved on high clock");
  property p_pin_clear;
    $fell(alarm_output_pin_1) && !$past(srst) |-> cs_recent;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("pin 1 fell alone");
endmodule
bind vafrc_top vafrc_top_asserts u_chk (.sys_clk(sys_clk), .srst(srst),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_dout(spi_dout), .record_done(record_done),
  .spectral_exceed(spectral_exceed), .capture_mode(capture_mode),
  .record_rate_enable(record_rate_enable), .alarm_output_pin_1(alarm_output_pin_1),
  .alarm_output_pin_2(alarm_output_pin_2), .fir_select(fir_select), .fir_bypass(fir_bypass),
  .decimation_rates_out(decimation_rates_out), .rate_enable_active(rate_enable_active));
`default_nettype wire

// File: vafrc_host.sv
// Serial host model that writes bytes and reads words
`timescale 1ns/1ps
`default_nettype none
module vafrc_host (
  input wire logic sys_clk,
  input wire logic spi_dout,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_din,
  output logic rd_valid,
  output logic [15:0] rd_word
);
  initial begin
    {spi_sclk, spi_cs_n, spi_din, rd_valid, rd_word} = {3'b110, 1'b0, 16'h0000};
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Half period of five cycles leaves the sampler margin over its one-cycle edge detect
  task automatic frame(input logic [15:0] w);
    tick(1);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      tick(5);
      spi_sclk = 1'b0;
      spi_din = w[i];
      tick(5);
      spi_sclk = 1'b1;
      rd_word[i] = spi_dout;
    end
    tick(5);
    spi_cs_n = 1'b1;
    spi_din = ~spi_din;
    tick(4);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frame({1'b1, a, d});
  endtask
  task automatic rd(input logic [6:0] a);
    frame({1'b0, a, 8'h00});
    frame(16'h0000);
    rd_valid = 1'b1;
    tick(1);
    rd_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb_vafrc_top.sv
// Self-checking bench of the configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_vafrc_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic spi_sclk, spi_cs_n, spi_din, spi_dout, rd_valid, record_done, system_sample;
  logic data_ready, alarm_output_pin_1, alarm_output_pin_2;
  logic [15:0] rd_word, temperature_value, supply_value, system_alarm_threshold;
  logic [15:0] decimation_rates_out, r;
  logic [6:0] error_events;
  logic [1:0] capture_mode;
  logic [3:0] record_rate_enable, rate_enable_active;
  logic [2:0] fir_bypass;
  vafrc_pkg::vafrc_spectral_t spectral_exceed;
  vafrc_pkg::vafrc_fir_sel_t fir_select;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int checked = 0;
  always #50 sys_clk = ~sys_clk;
  vafrc_top #(.DELAY_W(4)) u_dut (.sys_clk(sys_clk), .srst(srst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout), .record_done(record_done),
    .spectral_exceed(spectral_exceed), .system_sample(system_sample),
    .temperature_value(temperature_value), .supply_value(supply_value),
    .system_alarm_threshold(system_alarm_threshold), .error_events(error_events),
    .data_ready(data_ready), .capture_mode(capture_mode),
    .record_rate_enable(record_rate_enable), .alarm_output_pin_1(alarm_output_pin_1),
    .alarm_output_pin_2(alarm_output_pin_2), .fir_select(fir_select),
    .fir_bypass(fir_bypass), .decimation_rates_out(decimation_rates_out),
    .rate_enable_active(rate_enable_active));
  vafrc_host u_host (.sys_clk(sys_clk), .spi_dout(spi_dout), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_din(spi_din), .rd_valid(rd_valid), .rd_word(rd_word));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t saw %h wanted %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      check(rd_word, exp_q.pop_front());
    end
  end
  initial begin
    #5000000;
    num_errors++;
    close_out();
  end
  // ----------------------------------------
  // Stimulus helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] want);
    exp_q.push_back(want);
    u_host.rd(a);
  endtask
  task automatic rec(input logic [5:0] e);
    spectral_exceed = e;
    record_done = 1'b1;
    cyc(1);
    record_done = 1'b0;
    cyc(3);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {record_done, system_sample, data_ready, error_events, spectral_exceed} = '0;
    {capture_mode, record_rate_enable} = '0;
    temperature_value = 16'h0064;
    supply_value = 16'h00C8;
    system_alarm_threshold = 16'h0096;
    r = 16'($urandom(68063));
    cyc(6);
    srst = 1'b0;
    cyc(2);
    rd_chk(7'h34, 16'h0080);
    rd_chk(7'h38, 16'h0000);
    rd_chk(7'h3A, 16'h7421);
    rd_chk(7'h10, 16'h0000);
    check({13'h0000, fir_bypass}, 16'h0007);
    for (int c = 0; c < 7; c++) begin
      u_host.wr(7'h38, 8'(c));
      cyc(2);
      check({13'h0000, fir_bypass}, {13'h0000, 2'b11, c == 0});
      check({13'h0000, fir_select.x}, 16'(c));
    end
    u_host.wr(7'h38, 8'h71);
    u_host.wr(7'h39, 8'h01);
    rd_chk(7'h38, 16'h0171);
    check({4'h0, fir_select, fir_bypass}, 16'h03CA);
    r = 16'($urandom);
    u_host.wr(7'h39, r[7:0]);
    rd_chk(7'h38, {r[7:0], 8'h71} & 16'h0777);
    u_host.wr(7'h3A, r[15:8]);
    u_host.wr(7'h3B, 8'h35);
    rd_chk(7'h3A, {8'h35, r[15:8]});
    check(decimation_rates_out, {8'h35, r[15:8]});
    for (int m = 0; m < 4; m++) begin
      capture_mode = 2'(m);
      record_rate_enable = 4'($urandom);
      cyc(2);
      check({12'h000, rate_enable_active}, {12'h000, m == 3 ? 4'h0 : record_rate_enable});
    end
    u_host.wr(7'h34, 8'h41);
    u_host.wr(7'h35, 8'h02);
    rec(6'b000011);
    check({15'h0000, alarm_output_pin_1}, 16'h0000);
    rec(6'b000011);
    check({15'h0000, alarm_output_pin_1}, 16'h0001);
    rec(6'b001000);
    rec(6'b001000);
    check({15'h0000, alarm_output_pin_2}, 16'h0001);
    rd_chk(7'h3C, 16'h0900);
    rd_chk(7'h3C, 16'h0000);
    u_host.wr(7'h35, 8'h10);
    rec(6'b000001);
    rd_chk(7'h3C, 16'h0100);
    rd_chk(7'h3C, 16'h0100);
    u_host.wr(7'h3E, 8'h10);
    rd_chk(7'h3C, 16'h0000);
    u_host.wr(7'h34, 8'h01);
    rec(6'b000001);
    check({15'h0000, alarm_output_pin_1}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      u_host.wr(7'h34, {2'b10, k[1], k[0], 4'h8});
      u_host.wr(7'h3E, 8'h10);
      {system_sample, error_events} = 8'h81;
      cyc(1);
      {system_sample, error_events} = 8'h00;
      cyc(2);
      rd_chk(7'h3C, {1'b0, k == 0 || k == 3, 13'h0000, 1'b1});
    end
    u_host.wr(7'h34, 8'h00);
    u_host.wr(7'h3E, 8'h10);
    error_events = 7'h01;
    cyc(1);
    error_events = 7'h00;
    rd_chk(7'h3C, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
